/* File: logic/acf_pkg.sv */
package acf_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 15;
    localparam int PTR_W = 16;
    localparam int DEPTH = 32768;
    localparam int SLAVES = 5;
    localparam int SEL_W = 3;
    localparam int SPI_W = 16;
    localparam int CNT_W = 5;

    // reset hold in reference cycles, long enough for the write domain to see it
    localparam logic [CNT_W-1:0] RST_HOLD = 5'h10;
    // reference cycles per half period of the serial clock
    localparam logic [CNT_W-1:0] SPI_HALF = 5'h04;
    localparam logic [CNT_W-1:0] SPI_BITS = 5'h10;
    localparam logic [SEL_W-1:0] DEFAULT_SLAVE = 3'h0;
    localparam logic [SLAVES-1:0] SELECT_IDLE = 5'h1F;

    typedef struct packed {
        logic tie_clocks;
        logic no_rx_invert;
        logic xor_invert;
        logic interleave;
        logic top_first;
        logic dual;
    } acf_cfg_t;

    typedef struct packed {
        logic start;
        logic [SEL_W-1:0] channel;
        logic [SPI_W-1:0] wdata;
    } acf_spi_req_t;

    function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    // gray pointer that equals the other side's pointer one full lap ahead
    function automatic logic [PTR_W-1:0] lap_gray(input logic [PTR_W-1:0] g);
        lap_gray = {~g[PTR_W-1:PTR_W-2], g[PTR_W-3:0]};
    endfunction

endpackage

/* File: logic/acf_capture_channel.sv */
`timescale 1ns/1ns
module acf_capture_channel
    import acf_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic clear_in,
    input wire logic wr_clk_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    input wire logic late_in,
    input wire logic rd_pop_in,
    output logic [DATA_W-1:0] rd_data_out,
    output logic full_out,
    output logic empty_out
);

    logic [DATA_W-1:0] mem_reg [DEPTH];
    logic wr_clr_s1_reg, wr_clr_s2_reg;
    logic late_s1_reg, late_s2_reg;
    logic en_reg, en_late_reg;
    logic [PTR_W-1:0] rg_s1_reg, rg_s2_reg;
    logic [PTR_W-1:0] wr_bin_reg, wr_gray_reg;
    logic [PTR_W-1:0] wg_s1_reg, wg_s2_reg;
    logic [PTR_W-1:0] rd_bin_reg, rd_gray_reg;
    logic wr_done_reg;
    logic wr_full, we, wr_go;

    // write domain: runs on the capture clock only
    always_ff @(posedge wr_clk_in) begin
        wr_clr_s1_reg <= clear_in;
        wr_clr_s2_reg <= wr_clr_s1_reg;
        late_s1_reg <= late_in;
        late_s2_reg <= late_s1_reg;
        rg_s1_reg <= rd_gray_reg;
        rg_s2_reg <= rg_s1_reg;
    end

    // enable opens after the reset, one extra edge later on the late channel
    always_ff @(posedge wr_clk_in) begin
        en_reg <= ~wr_clr_s2_reg;
        en_late_reg <= en_reg & ~wr_clr_s2_reg;
    end

    assign we = late_s2_reg ? en_late_reg : en_reg;
    assign wr_full = (wr_gray_reg == lap_gray(rg_s2_reg));
    assign wr_go = we && !wr_full && !wr_done_reg;

    // capture ends at the first full; later reads must not reopen writing
    always_ff @(posedge wr_clk_in) begin
        if (wr_clr_s2_reg) begin
            wr_done_reg <= 1'b0;
        end else if (wr_full) begin
            wr_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge wr_clk_in) begin
        if (wr_clr_s2_reg) begin
            wr_bin_reg <= '0;
            wr_gray_reg <= '0;
        end else if (wr_go) begin
            wr_bin_reg <= wr_bin_reg + 16'h0001;
            wr_gray_reg <= to_gray(wr_bin_reg + 16'h0001);
        end
    end

    always_ff @(posedge wr_clk_in) begin
        if (!wr_clr_s2_reg && wr_go) begin
            mem_reg[wr_bin_reg[ADDR_W-1:0]] <= wr_data_in;
        end
    end

    // read domain: reference clock
    always_ff @(posedge sys_clk_in) begin
        wg_s1_reg <= wr_gray_reg;
        wg_s2_reg <= wg_s1_reg;
    end

    always_ff @(posedge sys_clk_in) begin
        if (clear_in) begin
            rd_bin_reg <= '0;
            rd_gray_reg <= '0;
        end else if (rd_pop_in && !empty_out) begin
            rd_bin_reg <= rd_bin_reg + 16'h0001;
            rd_gray_reg <= to_gray(rd_bin_reg + 16'h0001);
        end
    end

    assign empty_out = (rd_gray_reg == wg_s2_reg);
    assign full_out = (rd_gray_reg == lap_gray(wg_s2_reg));
    assign rd_data_out = mem_reg[rd_bin_reg[ADDR_W-1:0]];

endmodule

/* File: logic/acf_sequencer.sv */
// Functional notes
// - full fifos raise wake toward host
// - one shared 16-bit bus, selected fifo only
// - one sample per edge, 32k deep channel
// - each channel written by its own capture clock
// - option ties one capture clock to both
// - capture clock inverted by default, removable
// - second inversion defaults to pass-through
// - serial master addresses up to five slaves
// - serial clock and data shared by slaves
// - active-low selects, exactly one during transfer
// - first select default, software picks channel
// - interleaved write enables offset by one edge
// - option picks which fifo writes first
`timescale 1ns/1ns
module acf_sequencer
    import acf_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic capture_clock_one_in,
    input wire logic capture_clock_two_in,
    input wire logic [DATA_W-1:0] sample_bottom_in,
    input wire logic [DATA_W-1:0] sample_top_in,
    input wire acf_cfg_t cfg_in,
    input wire logic fifo_master_reset_in,
    input wire logic bottom_fifo_read_enable_in,
    input wire logic top_fifo_read_enable_in,
    input wire logic read_strobe_in,
    input wire acf_spi_req_t spi_req_in,
    input wire logic spi_miso_in,
    output logic [DATA_W-1:0] read_data_out,
    output logic read_valid_out,
    output logic read_bus_driven_out,
    output logic wake_out,
    output logic bottom_full_out,
    output logic top_full_out,
    output logic bottom_empty_out,
    output logic top_empty_out,
    output logic spi_sclk_out,
    output logic spi_mosi_out,
    output logic [SLAVES-1:0] slave_select_n_out,
    output logic spi_busy_out,
    output logic [SPI_W-1:0] spi_rdata_out
);

    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_LOW,
        SPI_HIGH,
        SPI_END
    } acf_spi_state_t;

    // host pins and straps pass two flip-flops first, except the clock straps and the serial channel and word, used directly
    logic [5:0] cfg_s1_reg, cfg_s2_reg;
    logic mrs_s1_reg, mrs_s2_reg, mrs_s3_reg;
    logic oe_b_s1_reg, oe_b_s2_reg;
    logic oe_t_s1_reg, oe_t_s2_reg;
    logic rstb_s1_reg, rstb_s2_reg, rstb_s3_reg;
    logic go_s1_reg, go_s2_reg, go_s3_reg;
    logic miso_s1_reg, miso_s2_reg;
    acf_cfg_t cfg;
    logic mrs_rise, rd_rise, go_rise;

    logic [CNT_W-1:0] hold_cnt_reg;
    logic clear_reg;

    logic clk_bottom_raw, clk_top_raw;
    logic clk_bottom_wr, clk_top_wr;

    logic [DATA_W-1:0] bottom_data, top_data;
    logic bottom_full, top_full, bottom_empty, top_empty;
    logic pop_bottom, pop_top;
    logic sel_bottom, sel_top;

    logic [DATA_W-1:0] read_data_reg;
    logic read_valid_reg, read_bus_driven_reg;
    logic wake_reg, wake_next;
    logic bottom_full_reg, top_full_reg, bottom_empty_reg, top_empty_reg;

    acf_spi_state_t spi_state_reg;
    logic [CNT_W-1:0] spi_div_reg, spi_bit_reg;
    logic [SPI_W-1:0] spi_tx_reg, spi_rx_reg;
    logic [SEL_W-1:0] spi_chan;
    logic spi_sclk_reg, spi_mosi_reg, spi_busy_reg;
    logic [SLAVES-1:0] select_n_reg;
    logic [SPI_W-1:0] spi_rdata_reg;

    always_ff @(posedge ref_clk_in) begin
        cfg_s1_reg <= cfg_in;
        cfg_s2_reg <= cfg_s1_reg;
        mrs_s1_reg <= fifo_master_reset_in;
        mrs_s2_reg <= mrs_s1_reg;
        mrs_s3_reg <= mrs_s2_reg;
        oe_b_s1_reg <= bottom_fifo_read_enable_in;
        oe_b_s2_reg <= oe_b_s1_reg;
        oe_t_s1_reg <= top_fifo_read_enable_in;
        oe_t_s2_reg <= oe_t_s1_reg;
        rstb_s1_reg <= read_strobe_in;
        rstb_s2_reg <= rstb_s1_reg;
        rstb_s3_reg <= rstb_s2_reg;
        go_s1_reg <= spi_req_in.start;
        go_s2_reg <= go_s1_reg;
        go_s3_reg <= go_s2_reg;
        miso_s1_reg <= spi_miso_in;
        miso_s2_reg <= miso_s1_reg;
    end

    assign cfg = acf_cfg_t'(cfg_s2_reg);
    assign mrs_rise = mrs_s2_reg & ~mrs_s3_reg;
    assign rd_rise = rstb_s2_reg & ~rstb_s3_reg;
    assign go_rise = go_s2_reg & ~go_s3_reg;

    // fifo clear is stretched so the slower capture domain always sees it
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            hold_cnt_reg <= RST_HOLD;
            clear_reg <= 1'b1;
        end else if (mrs_rise) begin
            hold_cnt_reg <= RST_HOLD;
            clear_reg <= 1'b1;
        end else if (hold_cnt_reg != '0) begin
            hold_cnt_reg <= hold_cnt_reg - 5'h01;
            clear_reg <= 1'b1;
        end else begin
            clear_reg <= 1'b0;
        end
    end

    // write clock paths; straps are static during a capture
    assign clk_bottom_raw = capture_clock_one_in;
    assign clk_top_raw = cfg_in.tie_clocks ? capture_clock_one_in : capture_clock_two_in;
    assign clk_bottom_wr = clk_bottom_raw ^ ~cfg_in.no_rx_invert ^ cfg_in.xor_invert;
    assign clk_top_wr = clk_top_raw ^ ~cfg_in.no_rx_invert ^ cfg_in.xor_invert;

    acf_capture_channel u_bottom (
        .sys_clk_in(ref_clk_in),
        .clear_in(clear_reg),
        .wr_clk_in(clk_bottom_wr),
        .wr_data_in(sample_bottom_in),
        .late_in(cfg.interleave & cfg.top_first),
        .rd_pop_in(pop_bottom),
        .rd_data_out(bottom_data),
        .full_out(bottom_full),
        .empty_out(bottom_empty)
    );

    acf_capture_channel u_top (
        .sys_clk_in(ref_clk_in),
        .clear_in(clear_reg),
        .wr_clk_in(clk_top_wr),
        .wr_data_in(sample_top_in),
        .late_in(cfg.interleave & ~cfg.top_first),
        .rd_pop_in(pop_top),
        .rd_data_out(top_data),
        .full_out(top_full),
        .empty_out(top_empty)
    );

    // exactly one enable drives the shared bus; both or none leaves it released
    assign sel_bottom = oe_b_s2_reg & ~oe_t_s2_reg;
    assign sel_top = oe_t_s2_reg & ~oe_b_s2_reg;
    assign pop_bottom = rd_rise & sel_bottom & ~clear_reg;
    assign pop_top = rd_rise & sel_top & ~clear_reg;

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            read_data_reg <= '0;
            read_valid_reg <= 1'b0;
            read_bus_driven_reg <= 1'b0;
        end else begin
            read_bus_driven_reg <= sel_bottom | sel_top;
            read_valid_reg <= (pop_bottom & ~bottom_empty) | (pop_top & ~top_empty);
            if (sel_bottom) begin
                read_data_reg <= bottom_data;
            end else if (sel_top) begin
                read_data_reg <= top_data;
            end else begin
                read_data_reg <= '0;
            end
        end
    end

    // wake: bottom full, and top full too in dual use; held until next clear
    always_comb begin
        wake_next = wake_reg;
        if (clear_reg) begin
            wake_next = 1'b0;
        end
        if (!clear_reg && bottom_full && (top_full || !cfg.dual)) begin
            wake_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            wake_reg <= 1'b0;
            bottom_full_reg <= 1'b0;
            top_full_reg <= 1'b0;
            bottom_empty_reg <= 1'b1;
            top_empty_reg <= 1'b1;
        end else begin
            wake_reg <= wake_next;
            bottom_full_reg <= bottom_full;
            top_full_reg <= top_full;
            bottom_empty_reg <= bottom_empty;
            top_empty_reg <= top_empty;
        end
    end

    // serial master, mode 0, msb first
    assign spi_chan = (spi_req_in.channel < SEL_W'(SLAVES)) ? spi_req_in.channel
                                                            : DEFAULT_SLAVE;

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            spi_state_reg <= SPI_IDLE;
            spi_div_reg <= '0;
            spi_bit_reg <= '0;
            spi_tx_reg <= '0;
            spi_rx_reg <= '0;
            spi_sclk_reg <= 1'b0;
            spi_mosi_reg <= 1'b0;
            spi_busy_reg <= 1'b0;
            select_n_reg <= SELECT_IDLE;
            spi_rdata_reg <= '0;
        end else begin
            case (spi_state_reg)
                SPI_IDLE: begin
                    spi_sclk_reg <= 1'b0;
                    select_n_reg <= SELECT_IDLE;
                    spi_busy_reg <= 1'b0;
                    if (go_rise) begin
                        select_n_reg <= ~(SLAVES'(1) << spi_chan);
                        spi_tx_reg <= {spi_req_in.wdata[SPI_W-2:0], 1'b0};
                        spi_mosi_reg <= spi_req_in.wdata[SPI_W-1];
                        spi_bit_reg <= SPI_BITS;
                        spi_div_reg <= SPI_HALF;
                        spi_busy_reg <= 1'b1;
                        spi_state_reg <= SPI_LOW;
                    end
                end
                SPI_LOW: begin
                    if (spi_div_reg == 5'h01) begin
                        spi_div_reg <= SPI_HALF;
                        spi_sclk_reg <= 1'b1;
                        spi_rx_reg <= {spi_rx_reg[SPI_W-2:0], miso_s2_reg};
                        spi_state_reg <= SPI_HIGH;
                    end else begin
                        spi_div_reg <= spi_div_reg - 5'h01;
                    end
                end
                SPI_HIGH: begin
                    if (spi_div_reg == 5'h01) begin
                        spi_div_reg <= SPI_HALF;
                        spi_sclk_reg <= 1'b0;
                        spi_bit_reg <= spi_bit_reg - 5'h01;
                        if (spi_bit_reg == 5'h01) begin
                            spi_state_reg <= SPI_END;
                        end else begin
                            spi_mosi_reg <= spi_tx_reg[SPI_W-1];
                            spi_tx_reg <= {spi_tx_reg[SPI_W-2:0], 1'b0};
                            spi_state_reg <= SPI_LOW;
                        end
                    end else begin
                        spi_div_reg <= spi_div_reg - 5'h01;
                    end
                end
                SPI_END: begin
                    if (spi_div_reg == 5'h01) begin
                        select_n_reg <= SELECT_IDLE;
                        spi_rdata_reg <= spi_rx_reg;
                        spi_busy_reg <= 1'b0;
                        spi_mosi_reg <= 1'b0;
                        spi_state_reg <= SPI_IDLE;
                    end else begin
                        spi_div_reg <= spi_div_reg - 5'h01;
                    end
                end
                default: begin
                    spi_state_reg <= SPI_IDLE;
                end
            endcase
        end
    end

    assign read_data_out = read_data_reg;
    assign read_valid_out = read_valid_reg;
    assign read_bus_driven_out = read_bus_driven_reg;
    assign wake_out = wake_reg;
    assign bottom_full_out = bottom_full_reg;
    assign top_full_out = top_full_reg;
    assign bottom_empty_out = bottom_empty_reg;
    assign top_empty_out = top_empty_reg;
    assign spi_sclk_out = spi_sclk_reg;
    assign spi_mosi_out = spi_mosi_reg;
    assign slave_select_n_out = select_n_reg;
    assign spi_busy_out = spi_busy_reg;
    assign spi_rdata_out = spi_rdata_reg;

endmodule

/* File: tb/acf_monitor.sv */
`timescale 1ns/1ns
module acf_monitor
    import acf_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire acf_cfg_t cfg_in,
    input wire logic [DATA_W-1:0] read_data_out,
    input wire logic read_valid_out,
    input wire logic read_bus_driven_out,
    input wire logic wake_out,
    input wire logic bottom_full_out,
    input wire logic top_full_out,
    input wire logic bottom_empty_out,
    input wire logic spi_sclk_out,
    input wire logic [SLAVES-1:0] slave_select_n_out,
    input wire logic spi_busy_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic [4:0] edges_reg;
    // counts serial clock rises within one transfer
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !spi_busy_out) begin
            edges_reg <= 5'h00;
        end else if ($rose(spi_sclk_out)) begin
            edges_reg <= edges_reg + 5'h01;
        end
    end
    sequence sclk_high_half;
        spi_sclk_out [*4];
    endsequence
    sequence sel_active;
        slave_select_n_out != SELECT_IDLE;
    endsequence
    a_sclk_half_period: assert property ($rose(spi_sclk_out) |-> sclk_high_half ##1 !spi_sclk_out)
        else $error("serial clock high phase wrong");
    a_sclk_idle_low: assert property (!spi_busy_out |-> !spi_sclk_out)
        else $error("serial clock toggles while idle");
    a_bit_count: assert property ($fell(spi_busy_out) |-> edges_reg == 5'h10)
        else $error("transfer bit count wrong");
    a_select_one_hot: assert property ($countones(~slave_select_n_out) <= 1)
        else $error("more than one select low");
    a_idle_deselect: assert property (!spi_busy_out |-> slave_select_n_out == SELECT_IDLE)
        else $error("select low while idle");
    a_start_selects: assert property ($rose(spi_busy_out) |-> ##[0:1] sel_active)
        else $error("no select at transfer start");
    a_bus_release: assert property (!read_bus_driven_out |-> read_data_out == '0)
        else $error("read bus not released");
    a_valid_pulse: assert property (read_valid_out |=> !read_valid_out)
        else $error("read valid longer than one cycle");
    a_valid_driven: assert property (read_valid_out |-> $past(read_bus_driven_out))
        else $error("pop without single enable");
    a_wake_full: assert property ($rose(wake_out) |-> bottom_full_out && (!cfg_in.dual || top_full_out))
        else $error("wake without full");
    a_flag_excl: assert property (!(bottom_full_out && bottom_empty_out))
        else $error("full and empty together");
endmodule

bind acf_sequencer acf_monitor acf_monitor_i (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .cfg_in(cfg_in),
    .read_data_out(read_data_out),
    .read_valid_out(read_valid_out),
    .read_bus_driven_out(read_bus_driven_out),
    .wake_out(wake_out),
    .bottom_full_out(bottom_full_out),
    .top_full_out(top_full_out),
    .bottom_empty_out(bottom_empty_out),
    .spi_sclk_out(spi_sclk_out),
    .slave_select_n_out(slave_select_n_out),
    .spi_busy_out(spi_busy_out)
);

/* File: tb/acf_source_model.sv */
`timescale 1ns/1ns
module acf_source_model
    import acf_pkg::*;
#(
    parameter logic [SPI_W-1:0] REPLY = 16'h3C5A
)
(
    output logic clk_one_out,
    output logic clk_two_out,
    output logic [DATA_W-1:0] bottom_out,
    output logic [DATA_W-1:0] top_out,
    input wire logic sclk_in,
    input wire logic mosi_in,
    input wire logic [SLAVES-1:0] sel_n_in,
    output logic miso_out,
    output logic [SPI_W-1:0] rx_word_out
);
    logic [DATA_W-1:0] count = 16'h0000;
    logic [SPI_W-1:0] tx = 16'h0000;
    logic picked;
    initial begin
        clk_one_out = 1'b0;
        miso_out = 1'b0;
        rx_word_out = 16'h0000;
        #7;
        forever #24 clk_one_out = ~clk_one_out;
    end
    assign clk_two_out = clk_one_out;
    // sample changes on the rising pin edge, mid-bit for the inverted path
    always @(posedge clk_one_out) count <= count + 16'h0001;
    assign bottom_out = count;
    assign top_out = count ^ 16'h8000;
    assign picked = (sel_n_in != SELECT_IDLE);
    always @(posedge picked) begin
        tx = REPLY;
        miso_out = REPLY[15];
    end
    always @(negedge sclk_in) if (picked) begin
        tx = {tx[14:0], 1'b0};
        miso_out = tx[15];
    end
    // released line shows no stale bit
    always @(negedge picked) miso_out = ~miso_out;
    always @(posedge sclk_in) if (picked) rx_word_out <= {rx_word_out[14:0], mosi_in};
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
    import acf_pkg::*;
    logic clk = 1'b0, rst = 1'b1, mrst = 1'b0, oe_b = 1'b0, oe_t = 1'b0, strobe = 1'b0;
    acf_cfg_t cfg = 6'h25;
    acf_spi_req_t req = '0;
    logic c1, c2, sclk, mosi, miso, rvalid, driven, wake, bfull, tfull, bempty, tempty, busy;
    logic [DATA_W-1:0] sb, st, rdata;
    logic [SLAVES-1:0] sel_n;
    logic [SPI_W-1:0] srx, rx_word;
    int err_total = 0, checked = 0;
    always #20 clk = ~clk;
    acf_sequencer acf_sequencer_i (.ref_clk_in(clk), .sys_rst_in(rst),
        .capture_clock_one_in(c1), .capture_clock_two_in(c2), .sample_bottom_in(sb),
        .sample_top_in(st), .cfg_in(cfg), .fifo_master_reset_in(mrst),
        .bottom_fifo_read_enable_in(oe_b), .top_fifo_read_enable_in(oe_t),
        .read_strobe_in(strobe), .spi_req_in(req), .spi_miso_in(miso),
        .read_data_out(rdata), .read_valid_out(rvalid), .read_bus_driven_out(driven),
        .wake_out(wake), .bottom_full_out(bfull), .top_full_out(tfull),
        .bottom_empty_out(bempty), .top_empty_out(tempty), .spi_sclk_out(sclk),
        .spi_mosi_out(mosi), .slave_select_n_out(sel_n), .spi_busy_out(busy),
        .spi_rdata_out(srx));
    acf_source_model acf_source_model_i (.clk_one_out(c1), .clk_two_out(c2),
        .bottom_out(sb), .top_out(st), .sclk_in(sclk), .mosi_in(mosi),
        .sel_n_in(sel_n), .miso_out(miso), .rx_word_out(rx_word));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_lvl(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        @(negedge clk);
        while (s !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        check("handshake", s, v);
        @(posedge clk);
    endtask
    task automatic spi_xfer(input logic [2:0] ch, input logic [15:0] w);
        logic [4:0] exp_sel;
        exp_sel = (ch > 3'h4) ? 5'h1E : ~(5'h01 << ch);
        req <= '{1'b1, ch, w};
        cyc(4);
        req.start <= 1'b0;
        cyc(16);
        @(negedge clk);
        check("select", sel_n, exp_sel);
        wait_lvl(busy, 1'b0, 300);
        check("mosi word", rx_word, w);
        check("miso word", srx, 16'h3C5A);
        cyc(3);
    endtask
    task automatic pop(output logic [15:0] w);
        @(negedge clk);
        w = rdata;
        @(posedge clk);
        strobe <= 1'b1;
        wait_lvl(rvalid, 1'b1, 10);
        strobe <= 1'b0;
        cyc(4);
    endtask
    initial begin
        cyc(60000);
        err_total++;
        tally_and_finish();
    end
    initial begin
        logic [15:0] b0, b1, t0, t1;
        cyc(12);
        rst <= 1'b0;
        @(negedge clk);
        check("idle select", sel_n, SELECT_IDLE);
        check("empty", bempty, 1'b1);
        check("top empty", tempty, 1'b1);
        check("wake", wake, 1'b0);
        cyc(20);
        for (int c = 0; c < 6; c++) begin
            spi_xfer(3'(c), 16'hA5C3 + 16'(c));
        end
        mrst <= 1'b1;
        cyc(4);
        mrst <= 1'b0;
        wait_lvl(wake, 1'b1, 45000);
        @(negedge clk);
        check("bottom full", bfull, 1'b1);
        check("top full", tfull, 1'b1);
        // host settle after wake, scaled down to keep the run short
        cyc(8);
        oe_b <= 1'b1;
        cyc(4);
        @(negedge clk);
        check("bus driven", driven, 1'b1);
        pop(b0);
        pop(b1);
        check("bottom order", b1, b0 + 16'h0001);
        check("bottom not full", bfull, 1'b0);
        oe_b <= 1'b0;
        oe_t <= 1'b1;
        cyc(4);
        pop(t0);
        pop(t1);
        check("top order", t1, t0 + 16'h0001);
        check("late channel", t0, b1 ^ 16'h8000);
        oe_b <= 1'b1;
        cyc(5);
        @(negedge clk);
        check("both driven", driven, 1'b0);
        check("both data", rdata, 16'h0000);
        @(posedge clk);
        strobe <= 1'b1;
        cyc(4);
        strobe <= 1'b0;
        cyc(2);
        oe_b <= 1'b0;
        cyc(5);
        @(negedge clk);
        check("no pop", rdata, t1 + 16'h0001);
        tally_and_finish();
    end
endmodule
